// >>> shared/rsa_pkg.sv
/*
 Package for the rotate/subtract/skip datapath: register map, field
 positions, reset values, operation codes and sequencer states.
 Assumes a 32-bit APB register bus with byte addresses on an 8-bit paddr.
*/
`default_nettype none

package rsa_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CMD   = 8'h00;
	localparam logic [7:0] ADDR_ACC   = 8'h04;
	localparam logic [7:0] ADDR_MEM   = 8'h08;
	localparam logic [7:0] ADDR_FLAGS = 8'h0C;
	localparam logic [7:0] ADDR_STAT  = 8'h10;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_BIT_LSB = 5;
	localparam int FLAG_C      = 0;
	localparam int FLAG_AC     = 1;
	localparam int FLAG_Z      = 2;
	localparam int FLAG_OV     = 3;

	// ------------------------------------------------------------
	// Reset values and cycle counts
	// ------------------------------------------------------------
	localparam logic [7:0] ACC_RST   = 8'h00;
	localparam logic [7:0] MEM_RST   = 8'h00;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic [1:0] CYC_PLAIN = 2'h1;
	localparam logic [1:0] CYC_SKIP  = 2'h2;

	// ------------------------------------------------------------
	// Operation codes
	// ------------------------------------------------------------
	localparam logic [4:0] OP_ROTL_CY_MEM = 5'h00;
	localparam logic [4:0] OP_ROTL_CY_ACC = 5'h01;
	localparam logic [4:0] OP_ROTR_MEM    = 5'h02;
	localparam logic [4:0] OP_ROTR_ACC    = 5'h03;
	localparam logic [4:0] OP_ROTR_CY_MEM = 5'h04;
	localparam logic [4:0] OP_ROTR_CY_ACC = 5'h05;
	localparam logic [4:0] OP_SBC_ACC     = 5'h06;
	localparam logic [4:0] OP_SBC_MEM     = 5'h07;
	localparam logic [4:0] OP_MINUS_ACC   = 5'h08;
	localparam logic [4:0] OP_MINUS_MEM   = 5'h09;
	localparam logic [4:0] OP_DECSZ_MEM   = 5'h0A;
	localparam logic [4:0] OP_DECSZ_ACC   = 5'h0B;
	localparam logic [4:0] OP_INCSZ_MEM   = 5'h0C;
	localparam logic [4:0] OP_INCSZ_ACC   = 5'h0D;
	localparam logic [4:0] OP_SKIP_BIT_NZ = 5'h0E;
	localparam logic [4:0] OP_FILL_ONES   = 5'h0F;
	localparam logic [4:0] OP_BIT_FORCE   = 5'h10;

	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RSA_IDLE  = 2'b00,
		RSA_EXEC  = 2'b01,
		RSA_DUMMY = 2'b10
	} rsa_state_t;

endpackage

`default_nettype wire

// >>> logic/rsa_alu.sv
/*
 Combinational execution unit: one operation on accumulator, memory byte
 and flags, giving the new values, write enables and the skip decision.
 Assumes the caller registers the results in the single execute cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module rsa_alu (
	input  wire logic [4:0] op,
	input  wire logic [2:0] bit_sel,
	input  wire logic [7:0] acc,
	input  wire logic [7:0] mem,
	input  wire logic [3:0] flags,
	output logic      [7:0] acc_out,
	output logic      [7:0] mem_out,
	output logic      [3:0] flags_out,
	output logic            acc_wr,
	output logic            mem_wr,
	output logic            skip,
	output logic            illegal
);

	// ------------------------------------------------------------
	// Shared adder
	// ------------------------------------------------------------
	logic       cin;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] dec_v;
	logic [7:0] inc_v;

	// Subtraction as addition of the complement; borrow-in is carry
	assign cin   = (op == rsa_pkg::OP_SBC_ACC || op == rsa_pkg::OP_SBC_MEM) ?
	               flags[rsa_pkg::FLAG_C] : 1'b1;
	assign sum   = {1'b0, acc} + {1'b0, ~mem} + {8'h00, cin};
	assign nib   = {1'b0, acc[3:0]} + {1'b0, ~mem[3:0]} + {4'h0, cin};
	assign dec_v = mem - 8'h01;
	assign inc_v = mem + 8'h01;

	// ------------------------------------------------------------
	// Operation decode
	// ------------------------------------------------------------
	always_comb begin
		acc_out   = acc;
		mem_out   = mem;
		flags_out = flags;
		acc_wr    = 1'b0;
		mem_wr    = 1'b0;
		skip      = 1'b0;
		illegal   = 1'b0;
		case (op)
			rsa_pkg::OP_ROTL_CY_MEM: begin
				mem_out = {mem[6:0], flags[rsa_pkg::FLAG_C]};
				mem_wr  = 1'b1;
				flags_out[rsa_pkg::FLAG_C] = mem[7];
			end
			rsa_pkg::OP_ROTL_CY_ACC: begin
				acc_out = {mem[6:0], flags[rsa_pkg::FLAG_C]};
				acc_wr  = 1'b1;
				flags_out[rsa_pkg::FLAG_C] = mem[7];
			end
			rsa_pkg::OP_ROTR_MEM: begin
				mem_out = {mem[0], mem[7:1]};
				mem_wr  = 1'b1;
			end
			rsa_pkg::OP_ROTR_ACC: begin
				acc_out = {mem[0], mem[7:1]};
				acc_wr  = 1'b1;
			end
			rsa_pkg::OP_ROTR_CY_MEM: begin
				mem_out = {flags[rsa_pkg::FLAG_C], mem[7:1]};
				mem_wr  = 1'b1;
				flags_out[rsa_pkg::FLAG_C] = mem[0];
			end
			rsa_pkg::OP_ROTR_CY_ACC: begin
				acc_out = {flags[rsa_pkg::FLAG_C], mem[7:1]};
				acc_wr  = 1'b1;
				flags_out[rsa_pkg::FLAG_C] = mem[0];
			end
			rsa_pkg::OP_SBC_ACC, rsa_pkg::OP_SBC_MEM,
			rsa_pkg::OP_MINUS_ACC, rsa_pkg::OP_MINUS_MEM: begin
				// Accumulator kept on the memory forms
				acc_wr = (op == rsa_pkg::OP_SBC_ACC || op == rsa_pkg::OP_MINUS_ACC);
				mem_wr = ~acc_wr;
				if (acc_wr) begin
					acc_out = sum[7:0];
				end else begin
					mem_out = sum[7:0];
				end
				// Carry high means no borrow
				flags_out[rsa_pkg::FLAG_C]  = sum[8];
				flags_out[rsa_pkg::FLAG_Z]  = (sum[7:0] == 8'h00);
				flags_out[rsa_pkg::FLAG_AC] = nib[4];
				flags_out[rsa_pkg::FLAG_OV] = (acc[7] != mem[7]) && (sum[7] != acc[7]);
			end
			rsa_pkg::OP_DECSZ_MEM: begin
				mem_out = dec_v;
				mem_wr  = 1'b1;
				skip    = (dec_v == 8'h00);
			end
			rsa_pkg::OP_DECSZ_ACC: begin
				acc_out = dec_v;
				acc_wr  = 1'b1;
				skip    = (dec_v == 8'h00);
			end
			rsa_pkg::OP_INCSZ_MEM: begin
				mem_out = inc_v;
				mem_wr  = 1'b1;
				skip    = (inc_v == 8'h00);
			end
			rsa_pkg::OP_INCSZ_ACC: begin
				acc_out = inc_v;
				acc_wr  = 1'b1;
				skip    = (inc_v == 8'h00);
			end
			rsa_pkg::OP_SKIP_BIT_NZ: begin
				skip = mem[bit_sel];
			end
			rsa_pkg::OP_FILL_ONES: begin
				mem_out = 8'hFF;
				mem_wr  = 1'b1;
			end
			rsa_pkg::OP_BIT_FORCE: begin
				mem_out = mem | (8'h01 << bit_sel);
				mem_wr  = 1'b1;
			end
			default: begin
				illegal = 1'b1;
			end
		endcase
	end

endmodule

`default_nettype wire

// >>> logic/rsa_core.sv
/*
 APB-reached execution datapath for rotate, subtract, step-and-skip and
 set operations on an accumulator, one data memory byte and four flags.
 Assumes an APB master on pclk; paddr is a byte address, data 32 bits.
*/
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module rsa_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [31:0]         prdata_r, prdata_nxt;
	logic                pready_r, pready_nxt;
	logic                pslverr_r, pslverr_nxt;
	rsa_pkg::rsa_state_t state_r, state_nxt;
	logic [4:0]          op_r, op_nxt;
	logic [2:0]          bit_r, bit_nxt;
	logic [7:0]          acc_r, acc_nxt;
	logic [7:0]          mem_r, mem_nxt;
	logic [3:0]          flags_r, flags_nxt;
	logic                skip_r, skip_nxt;
	logic                ill_r, ill_nxt;
	logic                memwr_r, memwr_nxt;
	logic                accwr_r, accwr_nxt;
	logic [1:0]          cyc_r, cyc_nxt;
	logic                wr_go;
	logic [7:0]          alu_acc, alu_mem;
	logic [3:0]          alu_flags;
	logic                alu_accwr, alu_memwr, alu_skip, alu_ill;

	// Known register offset check
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == rsa_pkg::ADDR_CMD) || (a == rsa_pkg::ADDR_ACC) ||
		          (a == rsa_pkg::ADDR_MEM) || (a == rsa_pkg::ADDR_FLAGS) ||
		          (a == rsa_pkg::ADDR_STAT);
	endfunction

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

	// Write commits only at the completing access edge
	assign wr_go = psel && penable && pready_r && pwrite && addr_ok(paddr);

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	// Ready raised by the setup cycle so every access takes one wait-free phase
	always_comb begin
		pready_nxt  = psel && !penable;
		pslverr_nxt = psel && !penable && !addr_ok(paddr);
		prdata_nxt  = prdata_r;
		if (psel && !penable) begin
			case (paddr)
				rsa_pkg::ADDR_CMD:   prdata_nxt = {24'h000000, bit_r, op_r};
				rsa_pkg::ADDR_ACC:   prdata_nxt = {24'h000000, acc_r};
				rsa_pkg::ADDR_MEM:   prdata_nxt = {24'h000000, mem_r};
				rsa_pkg::ADDR_FLAGS: prdata_nxt = {28'h0000000, flags_r};
				rsa_pkg::ADDR_STAT:  prdata_nxt = {22'h0, cyc_r, 3'h0, accwr_r,
				                                   memwr_r, ill_r, skip_r,
				                                   (state_r != rsa_pkg::RSA_IDLE)};
				default:             prdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h00000000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ------------------------------------------------------------
	// Execution unit
	// ------------------------------------------------------------
	rsa_alu u_alu (
		.op        (op_r),
		.bit_sel   (bit_r),
		.acc       (acc_r),
		.mem       (mem_r),
		.flags     (flags_r),
		.acc_out   (alu_acc),
		.mem_out   (alu_mem),
		.flags_out (alu_flags),
		.acc_wr    (alu_accwr),
		.mem_wr    (alu_memwr),
		.skip      (alu_skip),
		.illegal   (alu_ill)
	);

	// ------------------------------------------------------------
	// Sequencer and architectural state
	// ------------------------------------------------------------
	// Software writes are dropped while busy so results are never torn
	always_comb begin
		state_nxt = state_r;
		op_nxt    = op_r;
		bit_nxt   = bit_r;
		acc_nxt   = acc_r;
		mem_nxt   = mem_r;
		flags_nxt = flags_r;
		skip_nxt  = skip_r;
		ill_nxt   = ill_r;
		memwr_nxt = memwr_r;
		accwr_nxt = accwr_r;
		cyc_nxt   = cyc_r;
		case (state_r)
			rsa_pkg::RSA_IDLE: begin
				if (wr_go) begin
					case (paddr)
						rsa_pkg::ADDR_CMD: begin
							op_nxt    = pwdata[rsa_pkg::CMD_OP_LSB +: 5];
							bit_nxt   = pwdata[rsa_pkg::CMD_BIT_LSB +: 3];
							state_nxt = rsa_pkg::RSA_EXEC;
						end
						rsa_pkg::ADDR_ACC:   acc_nxt   = pwdata[7:0];
						rsa_pkg::ADDR_MEM:   mem_nxt   = pwdata[7:0];
						rsa_pkg::ADDR_FLAGS: flags_nxt = pwdata[3:0];
						default:             state_nxt = state_r;
					endcase
				end
			end
			rsa_pkg::RSA_EXEC: begin
				acc_nxt   = alu_acc;
				mem_nxt   = alu_mem;
				flags_nxt = alu_flags;
				skip_nxt  = alu_skip;
				ill_nxt   = alu_ill;
				memwr_nxt = alu_memwr;
				accwr_nxt = alu_accwr;
				// Discarded prefetch costs one dummy cycle
				cyc_nxt   = alu_skip ? rsa_pkg::CYC_SKIP : rsa_pkg::CYC_PLAIN;
				state_nxt = alu_skip ? rsa_pkg::RSA_DUMMY : rsa_pkg::RSA_IDLE;
			end
			rsa_pkg::RSA_DUMMY: begin
				state_nxt = rsa_pkg::RSA_IDLE;
			end
			default: begin
				state_nxt = rsa_pkg::RSA_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= rsa_pkg::RSA_IDLE;
			op_r    <= 5'h00;
			bit_r   <= 3'h0;
			acc_r   <= rsa_pkg::ACC_RST;
			mem_r   <= rsa_pkg::MEM_RST;
			flags_r <= rsa_pkg::FLAGS_RST;
			skip_r  <= 1'b0;
			ill_r   <= 1'b0;
			memwr_r <= 1'b0;
			accwr_r <= 1'b0;
			cyc_r   <= 2'h0;
		end else begin
			state_r <= state_nxt;
			op_r    <= op_nxt;
			bit_r   <= bit_nxt;
			acc_r   <= acc_nxt;
			mem_r   <= mem_nxt;
			flags_r <= flags_nxt;
			skip_r  <= skip_nxt;
			ill_r   <= ill_nxt;
			memwr_r <= memwr_nxt;
			accwr_r <= accwr_nxt;
			cyc_r   <= cyc_nxt;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Independent reference adder for the subtract checks
	logic [8:0] chk_sum;
	logic       chk_cin;
	logic       in_exec;
	assign in_exec = (state_r == rsa_pkg::RSA_EXEC);
	assign chk_cin = (op_r == rsa_pkg::OP_SBC_ACC || op_r == rsa_pkg::OP_SBC_MEM) ?
	                 flags_r[0] : 1'b1;
	assign chk_sum = {1'b0, acc_r} - {1'b0, mem_r} - {8'h00, !chk_cin};

	// Signed and low-nibble differences, worked apart from the adder
	logic [8:0] chk_sd;
	logic [4:0] chk_nib;
	assign chk_sd  = {acc_r[7], acc_r} - {mem_r[7], mem_r} - {8'h00, !chk_cin};
	assign chk_nib = {1'b0, acc_r[3:0]} - {1'b0, mem_r[3:0]} - {4'h0, !chk_cin};

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	rotl_cy_mem_a: assert property (in_exec && op_r == rsa_pkg::OP_ROTL_CY_MEM |=>
		mem_r == {$past(mem_r[6:0]), $past(flags_r[0])} && flags_r[0] == $past(mem_r[7])
		&& flags_r[3:1] == $past(flags_r[3:1]) && $stable(acc_r))
		else $error("left rotate through carry to memory wrong");
	rotl_cy_acc_a: assert property (in_exec && op_r == rsa_pkg::OP_ROTL_CY_ACC |=>
		acc_r == {$past(mem_r[6:0]), $past(flags_r[0])} && flags_r[0] == $past(mem_r[7])
		&& $stable(mem_r))
		else $error("left rotate through carry to accumulator wrong");
	rotr_mem_a: assert property (in_exec && op_r == rsa_pkg::OP_ROTR_MEM |=>
		mem_r == {$past(mem_r[0]), $past(mem_r[7:1])} && $stable(flags_r))
		else $error("right rotate to memory wrong");
	rotr_acc_a: assert property (in_exec && op_r == rsa_pkg::OP_ROTR_ACC |=>
		acc_r == {$past(mem_r[0]), $past(mem_r[7:1])} && $stable(flags_r) && $stable(mem_r))
		else $error("right rotate to accumulator wrong");
	rotr_cy_a: assert property (in_exec && (op_r == rsa_pkg::OP_ROTR_CY_MEM ||
		op_r == rsa_pkg::OP_ROTR_CY_ACC) |=> flags_r[0] == $past(mem_r[0]) &&
		(($past(op_r) == rsa_pkg::OP_ROTR_CY_MEM) ? mem_r : acc_r) ==
		{$past(flags_r[0]), $past(mem_r[7:1])} && flags_r[3:1] == $past(flags_r[3:1]) &&
		($past(op_r) == rsa_pkg::OP_ROTR_CY_ACC || $stable(acc_r)))
		else $error("right rotate through carry wrong");
	rotr_cy_acc_a: assert property (in_exec && op_r == rsa_pkg::OP_ROTR_CY_ACC |=>
		$stable(mem_r))
		else $error("right rotate through carry touched memory");
	sub_result_a: assert property (in_exec && (op_r == rsa_pkg::OP_SBC_ACC ||
		op_r == rsa_pkg::OP_MINUS_ACC) |=> acc_r == $past(chk_sum[7:0])
		&& flags_r[2] == ($past(chk_sum[7:0]) == 8'h00) && flags_r[0] == !$past(chk_sum[8]))
		else $error("subtract result or flags wrong");
	sub_to_mem_a: assert property (in_exec && (op_r == rsa_pkg::OP_SBC_MEM ||
		op_r == rsa_pkg::OP_MINUS_MEM) |=> $stable(acc_r) && mem_r == $past(chk_sum[7:0]))
		else $error("subtract to memory wrong");
	skip_dummy_a: assert property (in_exec && alu_skip |=>
		state_r == rsa_pkg::RSA_DUMMY ##1 state_r == rsa_pkg::RSA_IDLE)
		else $error("taken skip did not last two cycles");
	noskip_one_a: assert property (in_exec && !alu_skip |=>
		state_r == rsa_pkg::RSA_IDLE && cyc_r == rsa_pkg::CYC_PLAIN)
		else $error("untaken skip not one cycle");
	dec_skip_a: assert property (in_exec && op_r == rsa_pkg::OP_DECSZ_MEM |=>
		mem_r == $past(mem_r) - 8'h01 && skip_r == ($past(mem_r) == 8'h01) && $stable(flags_r))
		else $error("decrement and skip wrong");
	inc_skip_a: assert property (in_exec && op_r == rsa_pkg::OP_INCSZ_ACC |=>
		acc_r == $past(mem_r) + 8'h01 && skip_r == ($past(mem_r) == 8'hFF) && $stable(mem_r))
		else $error("increment to accumulator and skip wrong");
	bit_skip_a: assert property (in_exec && op_r == rsa_pkg::OP_SKIP_BIT_NZ |=>
		skip_r == $past(mem_r[bit_r]) && $stable(mem_r) && $stable(acc_r) && $stable(flags_r))
		else $error("bit test skip wrong");

	// Subtract flags on all four forms, from the signed and nibble differences
	sub_flags_a: assert property (in_exec && op_r >= rsa_pkg::OP_SBC_ACC &&
		op_r <= rsa_pkg::OP_MINUS_MEM |=>
		flags_r[3] == ($past(chk_sd[8]) != $past(chk_sd[7])) &&
		flags_r[2] == ($past(chk_sum[7:0]) == 8'h00) &&
		flags_r[1] == !$past(chk_nib[4]) && flags_r[0] == !$past(chk_sum[8]))
		else $error("subtract flags wrong");
	sub_keep_mem_a: assert property (in_exec && (op_r == rsa_pkg::OP_SBC_ACC ||
		op_r == rsa_pkg::OP_MINUS_ACC) |=> $stable(mem_r))
		else $error("subtract to accumulator touched memory");

	// Step-and-skip forms not covered above
	dec_acc_a: assert property (in_exec && op_r == rsa_pkg::OP_DECSZ_ACC |=>
		acc_r == $past(mem_r) - 8'h01 && skip_r == ($past(mem_r) == 8'h01)
		&& $stable(mem_r) && $stable(flags_r))
		else $error("decrement to accumulator and skip wrong");
	inc_mem_a: assert property (in_exec && op_r == rsa_pkg::OP_INCSZ_MEM |=>
		mem_r == $past(mem_r) + 8'h01 && skip_r == ($past(mem_r) == 8'hFF)
		&& $stable(acc_r) && $stable(flags_r))
		else $error("increment and skip wrong");

	// Set forms, the dummy cycle and unknown codes leave the rest alone
	fill_ones_a: assert property (in_exec && op_r == rsa_pkg::OP_FILL_ONES |=>
		mem_r == 8'hFF && $stable(acc_r) && $stable(flags_r))
		else $error("fill with ones wrong");
	bit_force_a: assert property (in_exec && op_r == rsa_pkg::OP_BIT_FORCE |=>
		mem_r[bit_r] && $countones(mem_r ^ $past(mem_r)) == int'(!$past(mem_r[bit_r]))
		&& $stable(flags_r) && $stable(acc_r))
		else $error("single bit set wrong");
	dummy_quiet_a: assert property (state_r == rsa_pkg::RSA_DUMMY |=>
		$stable(acc_r) && $stable(mem_r) && $stable(flags_r))
		else $error("dummy cycle changed state");
	ill_keep_a: assert property (in_exec && alu_ill |=>
		ill_r && $stable(acc_r) && $stable(mem_r) && $stable(flags_r))
		else $error("unknown operation changed state");

endmodule

`default_nettype wire

// >>> testbench/rsa_core_tb.sv
/*
 Self-checking bench for the rotate/subtract/skip datapath, driven over APB.
 Assumes the register map of rsa_pkg, the status layout of rsa_core and a 100 MHz pclk.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module rsa_core_tb;

	// ------------------------------------------------------------
	// Signals and design
	// ------------------------------------------------------------
	localparam logic [7:0] A_ACC = rsa_pkg::ADDR_ACC;
	localparam logic [7:0] A_MEM = rsa_pkg::ADDR_MEM;
	localparam logic [7:0] A_FLG = rsa_pkg::ADDR_FLAGS;
	localparam logic [7:0] A_ST  = rsa_pkg::ADDR_STAT;

	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] mem;
		logic [3:0] flg;
		logic       skip;
		logic       ill;
	} rsa_tb_exp_t;

	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	int          failures = 0;
	int          checks   = 0;

	// Free-running 100 MHz clock
	always #5 pclk = ~pclk;

	rsa_core i_rsa_core (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr)
	);

	// ------------------------------------------------------------
	// Expected results
	// ------------------------------------------------------------
	function automatic rsa_tb_exp_t model(input logic [4:0] op, input logic [2:0] b,
		input logic [7:0] a, input logic [7:0] m, input logic [3:0] f);
		rsa_tb_exp_t e;
		logic        ci;
		logic [8:0]  s;
		logic [4:0]  h;
		logic [3:0]  fs;
		e = '{acc: a, mem: m, flg: f, skip: 1'b0, ill: 1'b0};
		// Borrow form feeds the carry in, plain subtract feeds one
		ci = (op == 5'h06 || op == 5'h07) ? f[0] : 1'b1;
		s = {1'b0, a} + {1'b0, ~m} + {8'h00, ci};
		h = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, ci};
		fs = {(a[7] ^ m[7]) & (s[7] ^ a[7]), s[7:0] == 8'h00, h[4], s[8]};
		case (op)
			5'h00: begin
				e.mem = {m[6:0], f[0]};
				e.flg[0] = m[7];
			end
			5'h01: begin
				e.acc = {m[6:0], f[0]};
				e.flg[0] = m[7];
			end
			5'h02: e.mem = {m[0], m[7:1]};
			5'h03: e.acc = {m[0], m[7:1]};
			5'h04: begin
				e.mem = {f[0], m[7:1]};
				e.flg[0] = m[0];
			end
			5'h05: begin
				e.acc = {f[0], m[7:1]};
				e.flg[0] = m[0];
			end
			5'h06, 5'h08: begin
				e.acc = s[7:0];
				e.flg = fs;
			end
			5'h07, 5'h09: begin
				e.mem = s[7:0];
				e.flg = fs;
			end
			5'h0A: begin
				e.mem = m - 8'h01;
				e.skip = (m == 8'h01);
			end
			5'h0B: begin
				e.acc = m - 8'h01;
				e.skip = (m == 8'h01);
			end
			5'h0C: begin
				e.mem = m + 8'h01;
				e.skip = (m == 8'hFF);
			end
			5'h0D: begin
				e.acc = m + 8'h01;
				e.skip = (m == 8'hFF);
			end
			5'h0E: e.skip = m[b];
			5'h0F: e.mem = 8'hFF;
			5'h10: e.mem[b] = 1'b1;
			default: e.ill = 1'b1;
		endcase
		return e;
	endfunction

	// Which side each operation writes: {accumulator, memory}
	function automatic logic [1:0] dest(input logic [4:0] op);
		case (op)
			5'h01, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0B, 5'h0D: dest = 2'h2;
			5'h00, 5'h02, 5'h04, 5'h07, 5'h09, 5'h0A, 5'h0C, 5'h0F, 5'h10: dest = 2'h1;
			default: dest = 2'h0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	// Entered just after an edge; leaves the request up so a caller may chain
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n == 20)
			failures++;
		q = prdata;
		e = pslverr;
	endtask

	task automatic idle;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		idle;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
		apb(1'b0, a, 32'h0000_0000, q, e);
		idle;
	endtask

	// Bounded poll of the busy bit
	task automatic wait_idle;
		logic [31:0] q;
		logic        e;
		int          n;
		n = 0;
		rd(A_ST, q, e);
		while (q[0] !== 1'b0 && n < 30) begin
			rd(A_ST, q, e);
			n++;
		end
		if (n == 30)
			failures++;
	endtask

	// One operation: {op, bit, acc, mem, flags}
	task automatic run_op(input logic [27:0] v);
		rsa_tb_exp_t x;
		logic [31:0] q;
		logic        e;
		x = model(v[27:23], v[22:20], v[19:12], v[11:4], v[3:0]);
		wr(A_ACC, {24'h0, v[19:12]});
		wr(A_MEM, {24'h0, v[11:4]});
		wr(A_FLG, {28'h0, v[3:0]});
		wr(rsa_pkg::ADDR_CMD, {24'h0, v[22:20], v[27:23]});
		wait_idle;
		rd(A_ACC, q, e);
		`CHK(q, {24'h0, x.acc})
		rd(A_MEM, q, e);
		`CHK(q, {24'h0, x.mem})
		rd(A_FLG, q, e);
		`CHK(q, {28'h0, x.flg})
		rd(A_ST, q, e);
		`CHK(q[2:1], {x.ill, x.skip})
		`CHK(q[9:8], (x.skip ? 2'h2 : 2'h1))
		`CHK(q[4:3], dest(v[27:23]))
	endtask

	task automatic close_out;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Corner cases: wraps, borrow, overflow, zero, every skip edge
	// ------------------------------------------------------------
	logic [27:0] cor [11] = '{
		{5'h0A, 3'h0, 8'h00, 8'h01, 4'h0}, {5'h0A, 3'h0, 8'h00, 8'h00, 4'hF},
		{5'h0B, 3'h0, 8'h33, 8'h01, 4'h5}, {5'h0C, 3'h0, 8'h00, 8'hFF, 4'hA},
		{5'h0D, 3'h0, 8'h44, 8'hFF, 4'h0}, {5'h06, 3'h0, 8'h55, 8'h55, 4'h1},
		{5'h06, 3'h0, 8'h00, 8'h01, 4'h0}, {5'h09, 3'h0, 8'h80, 8'h01, 4'h0},
		{5'h0E, 3'h7, 8'h00, 8'h80, 4'h0}, {5'h0E, 3'h0, 8'h00, 8'hFE, 4'h0},
		{5'h1F, 3'h0, 8'h12, 8'h34, 4'h6}
	};

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] q;
		logic        e;
		logic [31:0] r;
		void'($urandom(32'h46C4));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (cor[i]) begin
			rd(A_ACC + 8'(4 * i % 16), q, e);
			`CHK(q, 32'h0000_0000)
		end
		// Unmapped place answers with an error and zero data
		rd(8'h14, q, e);
		`CHK({e, q}, 33'h1_0000_0000)
		// Status is read-only
		wr(A_ST, 32'hFFFF_FFFF);
		rd(A_ST, q, e);
		`CHK(q, 32'h0000_0000)
		foreach (cor[i])
			run_op(cor[i]);
		// Every operation code at least once
		for (int k = 0; k < 17; k++) begin
			r = $urandom;
			run_op({5'(k), r[22:0]});
		end
		repeat (150) begin
			r = $urandom;
			run_op(r[27:0]);
		end
		// Write chained onto a skipping command lands in the dummy cycle
		wr(A_MEM, 32'h0000_0080);
		wr(A_ACC, 32'h0000_0011);
		apb(1'b1, rsa_pkg::ADDR_CMD, {24'h0, 3'h7, 5'h0E}, q, e);
		apb(1'b1, A_ACC, 32'h0000_0022, q, e);
		idle;
		wait_idle;
		rd(A_ACC, q, e);
		`CHK(q, 32'h0000_0011)
		// Second reset in mid-run clears the state
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(A_MEM, q, e);
		`CHK(q, 32'h0000_0000)
		rd(A_ACC, q, e);
		`CHK(q, 32'h0000_0000)
		rd(A_ST, q, e);
		`CHK(q, 32'h0000_0000)
		close_out;
	end

	// Hang guard, several times the few thousand cycles the run needs
	initial begin
		#400_000;
		failures++;
		close_out;
	end

endmodule

`default_nettype wire
